// File: inc/sddc_cfg.svh
// Register map, field positions, reset values and codes of the detector.
`ifndef SDDC_CFG_SVH
`define SDDC_CFG_SVH
`define SDDC_DATA_W 8
`define SDDC_ADDR_W 2
`define SDDC_TRIP_W 4
`define SDDC_EV_W 2
`define SDDC_ADDR_CTRL 2'h0
`define SDDC_ADDR_STAT 2'h1
`define SDDC_ADDR_MASK 2'h2
`define SDDC_BIT_STABLE 5
`define SDDC_BIT_EN 4
`define SDDC_TRIP_MSB 3
`define SDDC_RSVD_MSB 7
`define SDDC_RSVD_LSB 6
`define SDDC_TRIP_EXT 4'hF
`define SDDC_TRIP_RSVD 4'h0
`define SDDC_TRIP_RST 4'h5
`define SDDC_EN_RST 1'b0
`define SDDC_EV_LV 0
`define SDDC_EV_REF 1
`define SDDC_EV_RST 2'h0
`define SDDC_DATA_ZERO 8'h00
`define SDDC_SYNC_STAGES 2
`endif

// File: inc/sddc_pkg.sv
// Types shared by the supply drop detector control logic.
`include "sddc_cfg.svh"
package sddc_pkg;
    typedef enum logic [2:0] {
        SDDC_OFF = 3'b001,
        SDDC_SETTLE = 3'b010,
        SDDC_READY = 3'b100
    } sddc_ref_e;

    typedef struct packed {
        logic en;
        logic [`SDDC_TRIP_W-1:0] trip;
        logic ext_sel;
        sddc_ref_e ref_st;
        logic [`SDDC_EV_W-1:0] status;
        logic [`SDDC_EV_W-1:0] mask;
        logic [`SDDC_DATA_W-1:0] rdata;
    } sddc_state_s;
endpackage

// File: core/sddc_sync.sv
// Two-stage synchroniser for asynchronous levels from the analogue side.
`include "sddc_cfg.svh"
module sddc_sync import sddc_pkg::*; #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [`SDDC_SYNC_STAGES-1:0][WIDTH-1:0] stage;
    logic [`SDDC_SYNC_STAGES-1:0][WIDTH-1:0] next_stage;

    // The first stage feeds only the second stage.
    always_comb begin
        next_stage[0] = async_i;
        next_stage[1] = stage[0];
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            stage <= '0;
        end else begin
            stage <= next_stage;
        end
    end

    assign sync_o = stage[1];
endmodule

// File: core/sddc_ctrl.sv
// Control and status logic of the supply drop detector.
// Behaviour
// - Control bits 7-6 always read zero.
// - Bit 5 reference-stable flag, read only, reset zero.
// - Bit 4 powers detector up or down.
// - Four-bit trip level, code zero reserved.
// - Code 1111 selects the external trip input.
// - No low-voltage flag before reference is stable.
// - Settling time comes from analogue, not clock.
// - Running shared reference skips the settling wait.
// - Cleared flag sets again while supply low.
// - Detector works in sleep and wakes device.
// - Wake vectors only when interrupts globally enabled.
// - Any reset restores control and powers down.
// - Stable comparator below set point sets flag.
//
// Our own choices: the plain strobed port and the address map.
`include "sddc_cfg.svh"
module sddc_ctrl import sddc_pkg::*; (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [`SDDC_ADDR_W-1:0] addr_i,
    input wire logic [`SDDC_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`SDDC_DATA_W-1:0] rdata_o,
    input wire logic comparator_below_i,
    input wire logic ref_ready_i,
    input wire logic bor_ref_running_i,
    input wire logic global_irq_enable_i,
    output logic detect_power_enable_o,
    output logic [`SDDC_TRIP_W-1:0] trip_level_select_o,
    output logic ext_input_select_o,
    output logic ref_settle_o,
    output logic ref_stable_flag_o,
    output logic wake_o,
    output logic irq_o,
    output logic irq_vector_o
);
    sddc_state_s st;
    sddc_state_s next_st;
    logic below_sync;
    logic ready_sync;
    logic bor_sync;
    logic lv_set;
    logic ref_set;
    logic [`SDDC_EV_W-1:0] ev_set;
    logic [`SDDC_EV_W-1:0] ev_clr;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic stable;
    sddc_ref_e next_ref;

    // Comparator, settled-reference and shared-reference levels are
    // asynchronous to clk_i and are retimed before any flag uses them.
    sddc_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i({comparator_below_i, ref_ready_i, bor_ref_running_i}),
        .sync_o({below_sync, ready_sync, bor_sync})
    );

    assign wr_ctrl = wr_i && (addr_i == `SDDC_ADDR_CTRL);
    assign wr_stat = wr_i && (addr_i == `SDDC_ADDR_STAT);
    assign wr_mask = wr_i && (addr_i == `SDDC_ADDR_MASK);
    // The stable flag drops in the same cycle as the power enable.
    assign stable = (st.ref_st == SDDC_READY) && st.en;

    // The flag is only trusted once the reference has settled, and it is
    // a level condition, so a clear while the supply is low sets it again.
    assign lv_set = st.en && stable && below_sync;
    assign ref_set = (st.ref_st != SDDC_READY) &&
                     (next_ref == SDDC_READY);

    // The reference state has its own process, so that the stable event
    // sees the transition without a loop back through next_st.
    always_comb begin
        next_ref = st.ref_st;
        case (st.ref_st)
            SDDC_OFF: begin
                if (st.en) begin
                    // Shared reference already up: no wait.
                    next_ref = bor_sync ? SDDC_READY : SDDC_SETTLE;
                end
            end
            SDDC_SETTLE: begin
                if (!st.en) begin
                    next_ref = SDDC_OFF;
                end else if (ready_sync) begin
                    // The wait ends on the analogue ready, no cycle count.
                    next_ref = SDDC_READY;
                end
            end
            SDDC_READY: begin
                if (!st.en) begin
                    next_ref = SDDC_OFF;
                end
            end
            default: begin
                next_ref = SDDC_OFF;
            end
        endcase
    end

    always_comb begin
        ev_set = `SDDC_EV_RST;
        ev_set[`SDDC_EV_LV] = lv_set;
        ev_set[`SDDC_EV_REF] = ref_set;
        ev_clr = wr_stat ? wdata_i[`SDDC_EV_W-1:0] : `SDDC_EV_RST;
    end

    always_comb begin
        next_st = st;
        if (wr_ctrl) begin
            next_st.en = wdata_i[`SDDC_BIT_EN];
            next_st.trip = wdata_i[`SDDC_TRIP_MSB:0];
            next_st.ext_sel =
                (wdata_i[`SDDC_TRIP_MSB:0] == `SDDC_TRIP_EXT);
        end
        if (wr_mask) begin
            next_st.mask = wdata_i[`SDDC_EV_W-1:0];
        end
        // A set arriving with its clear wins.
        next_st.status = (st.status & ~ev_clr) | ev_set;
        next_st.ref_st = next_ref;
        next_st.rdata = `SDDC_DATA_ZERO;
        if (rd_i) begin
            case (addr_i)
                `SDDC_ADDR_CTRL: begin
                    next_st.rdata[`SDDC_BIT_STABLE] = stable;
                    next_st.rdata[`SDDC_BIT_EN] = st.en;
                    next_st.rdata[`SDDC_TRIP_MSB:0] = st.trip;
                end
                `SDDC_ADDR_STAT: begin
                    next_st.rdata[`SDDC_EV_W-1:0] = st.status;
                end
                `SDDC_ADDR_MASK: begin
                    next_st.rdata[`SDDC_EV_W-1:0] = st.mask;
                end
                default: begin
                    next_st.rdata = `SDDC_DATA_ZERO;
                end
            endcase
        end
    end

    // Every reset returns the control register to its reset value.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st.en <= `SDDC_EN_RST;
            st.trip <= `SDDC_TRIP_RST;
            st.ext_sel <= 1'b0;
            st.ref_st <= SDDC_OFF;
            st.status <= `SDDC_EV_RST;
            st.mask <= `SDDC_EV_RST;
            st.rdata <= `SDDC_DATA_ZERO;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign detect_power_enable_o = st.en;
    assign trip_level_select_o = st.trip;
    assign ext_input_select_o = st.ext_sel;
    assign ref_settle_o = (st.ref_st == SDDC_SETTLE);
    assign ref_stable_flag_o = stable;
    // Wake needs no clock-gated path: the detector logic keeps running.
    assign wake_o = st.status[`SDDC_EV_LV];
    assign irq_o = |(st.status & st.mask);
    assign irq_vector_o = irq_o && global_irq_enable_i;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    property p_rsvd_zero;
        rd_i |=> (rdata_o[`SDDC_RSVD_MSB:`SDDC_RSVD_LSB] == 2'h0);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("Reserved control bits read nonzero.");

    property p_stable_read;
        (rd_i && addr_i == `SDDC_ADDR_CTRL)
            |=> (rdata_o[`SDDC_BIT_STABLE] == $past(stable));
    endproperty
    a_stable_read: assert property (p_stable_read)
        else $error("Stable flag read does not match state.");

    property p_power_follows;
        wr_ctrl |=> (detect_power_enable_o == $past(wdata_i[`SDDC_BIT_EN]));
    endproperty
    a_power_follows: assert property (p_power_follows)
        else $error("Power enable did not follow the write.");

    property p_trip_follows;
        wr_ctrl
            |=> (trip_level_select_o == $past(wdata_i[`SDDC_TRIP_MSB:0]));
    endproperty
    a_trip_follows: assert property (p_trip_follows)
        else $error("Trip level did not follow the write.");

    property p_ext_sel;
        ##1 (ext_input_select_o == (trip_level_select_o == `SDDC_TRIP_EXT));
    endproperty
    a_ext_sel: assert property (p_ext_sel)
        else $error("External input select disagrees with trip code.");

    property p_no_flag_unstable;
        (!stable && !st.status[`SDDC_EV_LV])
            |=> !st.status[`SDDC_EV_LV];
    endproperty
    a_no_flag_unstable: assert property (p_no_flag_unstable)
        else $error("Low-voltage flag set before reference stable.");

    property p_settle_waits;
        (st.ref_st == SDDC_SETTLE && st.en && !ready_sync)
            |=> (st.ref_st == SDDC_SETTLE);
    endproperty
    a_settle_waits: assert property (p_settle_waits)
        else $error("Settling ended without analogue ready.");

    property p_bor_skip;
        (st.ref_st == SDDC_OFF && st.en)
            |=> (st.ref_st == ($past(bor_sync) ? SDDC_READY : SDDC_SETTLE));
    endproperty
    a_bor_skip: assert property (p_bor_skip)
        else $error("Enable did not start or skip the wait correctly.");

    property p_reassert;
        (lv_set && wr_stat && wdata_i[`SDDC_EV_LV])
            |=> st.status[`SDDC_EV_LV];
    endproperty
    a_reassert: assert property (p_reassert)
        else $error("Clear beat a pending low-voltage set.");

    property p_wake;
        lv_set |=> wake_o;
    endproperty
    a_wake: assert property (p_wake)
        else $error("Low supply did not raise wake.");

    property p_vector;
        irq_vector_o |-> (global_irq_enable_i && irq_o);
    endproperty
    a_vector: assert property (p_vector)
        else $error("Vector taken without global interrupt enable.");

    property p_reset_off;
        disable iff (1'b0)
        reset_i |=> (!detect_power_enable_o &&
                     trip_level_select_o == `SDDC_TRIP_RST &&
                     !ref_stable_flag_o);
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("Reset did not restore the control register.");

    property p_flag_needs_below;
        (st.en && stable && !st.status[`SDDC_EV_LV] &&
         $past(comparator_below_i, 2) && !$past(reset_i, 2))
            |=> st.status[`SDDC_EV_LV];
    endproperty
    a_flag_needs_below: assert property (p_flag_needs_below)
        else $error("Comparator low did not set the flag.");

    property p_sync_lag;
        ##2 (below_sync == $past(comparator_below_i, 2));
    endproperty
    a_sync_lag: assert property (p_sync_lag)
        else $error("Comparator synchroniser is not two stages.");

    property p_rdata_idle;
        !rd_i |=> (rdata_o == `SDDC_DATA_ZERO);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("Read data not zero outside a read.");

    property p_power_hold;
        !wr_ctrl |=> $stable(detect_power_enable_o);
    endproperty
    a_power_hold: assert property (p_power_hold)
        else $error("Power enable changed without a control write.");

    property p_power_down_off;
        (st.ref_st != SDDC_OFF && !st.en) |=> (st.ref_st == SDDC_OFF);
    endproperty
    a_power_down_off: assert property (p_power_down_off)
        else $error("Reference state kept running after power down.");

    property p_trip_hold;
        !wr_ctrl |=> $stable(trip_level_select_o);
    endproperty
    a_trip_hold: assert property (p_trip_hold)
        else $error("Trip level changed without a control write.");

    property p_settle_ends;
        (st.ref_st == SDDC_SETTLE && st.en && ready_sync && !wr_ctrl)
            |=> ref_stable_flag_o;
    endproperty
    a_settle_ends: assert property (p_settle_ends)
        else $error("Settled reference did not raise the stable flag.");

    property p_ref_event;
        (st.ref_st == SDDC_SETTLE && st.en && ready_sync)
            |=> st.status[`SDDC_EV_REF];
    endproperty
    a_ref_event: assert property (p_ref_event)
        else $error("Stable event not recorded in status.");

    property p_flag_sticky;
        (st.status[`SDDC_EV_LV] && !(wr_stat && wdata_i[`SDDC_EV_LV]))
            |=> st.status[`SDDC_EV_LV];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("Low-voltage flag dropped without a clear.");

    property p_wake_clear;
        (!lv_set && wr_stat && wdata_i[`SDDC_EV_LV])
            |=> !wake_o;
    endproperty
    a_wake_clear: assert property (p_wake_clear)
        else $error("Wake stayed high after a clear with supply good.");

    property p_status_read;
        (rd_i && addr_i == `SDDC_ADDR_STAT)
            |=> (rdata_o[`SDDC_EV_W-1:0] == $past(st.status));
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("Status read does not match the flags.");

    property p_mask_follows;
        wr_mask
            |=> (st.mask == $past(wdata_i[`SDDC_EV_W-1:0]));
    endproperty
    a_mask_follows: assert property (p_mask_follows)
        else $error("Interrupt mask did not follow the write.");

    c_enable_ready: cover property (
        (st.ref_st == SDDC_SETTLE) ##[1:20] ref_stable_flag_o);
    c_flag_set: cover property (lv_set ##1 wake_o);
    c_vector: cover property (irq_vector_o);
    c_clear_reset: cover property (wr_stat && lv_set);
    c_power_down: cover property (st.ref_st == SDDC_READY && !st.en);
endmodule

// File: bench/sddc_tb.sv
// Self-checking testbench of the supply drop detector control logic.
`include "sddc_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [`SDDC_ADDR_W-1:0] addr_i = 2'h0;
    logic [`SDDC_DATA_W-1:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [`SDDC_DATA_W-1:0] rdata_o;
    logic comparator_below_i = 1'b0;
    logic ref_ready_i = 1'b0;
    logic bor_ref_running_i = 1'b0;
    logic global_irq_enable_i = 1'b0;
    logic detect_power_enable_o;
    logic [`SDDC_TRIP_W-1:0] trip_level_select_o;
    logic ext_input_select_o;
    logic ref_settle_o;
    logic ref_stable_flag_o;
    logic wake_o;
    logic irq_o;
    logic irq_vector_o;
    int num_errors = 0;
    int checked = 0;

    always #20 clk_i = ~clk_i;

    sddc_ctrl i_dut (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .comparator_below_i(comparator_below_i),
        .ref_ready_i(ref_ready_i),
        .bor_ref_running_i(bor_ref_running_i),
        .global_irq_enable_i(global_irq_enable_i),
        .detect_power_enable_o(detect_power_enable_o),
        .trip_level_select_o(trip_level_select_o),
        .ext_input_select_o(ext_input_select_o),
        .ref_settle_o(ref_settle_o),
        .ref_stable_flag_o(ref_stable_flag_o),
        .wake_o(wake_o),
        .irq_o(irq_o),
        .irq_vector_o(irq_vector_o)
    );

    task automatic finish_test();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen,
            input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rdchk(input logic [1:0] a, input logic [7:0] exp,
            input string what);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(what, rdata_o, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wait_stable();
        int n;
        n = 0;
        #1;
        while (ref_stable_flag_o !== 1'b1 && n < 50) begin
            idle(1);
            n++;
        end
        if (ref_stable_flag_o !== 1'b1) begin
            chk("ref_stable_flag_o", 8'(ref_stable_flag_o), 8'h01);
            finish_test();
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        chk("run_length", 8'h01, 8'h00);
        finish_test();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        rdchk(`SDDC_ADDR_CTRL, 8'h05, "ctrl_reset");
        chk("power", 8'(detect_power_enable_o), 8'h00);
        wr(`SDDC_ADDR_CTRL, 8'h0F);
        chk("trip_first", 8'(trip_level_select_o), 8'h0F);
        wr(`SDDC_ADDR_CTRL, 8'hDF);
        chk("power", 8'(detect_power_enable_o), 8'h01);
        chk("ext", 8'(ext_input_select_o), 8'h01);
        @(posedge clk_i);
        comparator_below_i <= 1'b1;
        idle(4);
        chk("settle", 8'(ref_settle_o), 8'h01);
        rdchk(`SDDC_ADDR_CTRL, 8'h1F, "ctrl_enabled");
        rdchk(`SDDC_ADDR_STAT, 8'h00, "status_unstable");
        @(posedge clk_i);
        ref_ready_i <= 1'b1;
        wait_stable();
        rdchk(`SDDC_ADDR_CTRL, 8'h3F, "ctrl_stable");
        idle(4);
        rdchk(`SDDC_ADDR_STAT, 8'h03, "status_low");
        chk("wake", 8'(wake_o), 8'h01);
        chk("irq_masked", 8'(irq_o), 8'h00);
        // Clearing while the supply is still low must not stick.
        wr(`SDDC_ADDR_STAT, 8'h03);
        idle(4);
        rdchk(`SDDC_ADDR_STAT, 8'h01, "status_reset");
        wr(`SDDC_ADDR_MASK, 8'h01);
        chk("irq", 8'(irq_o), 8'h01);
        chk("vector_off", 8'(irq_vector_o), 8'h00);
        @(posedge clk_i);
        global_irq_enable_i <= 1'b1;
        idle(1);
        chk("vector_on", 8'(irq_vector_o), 8'h01);
        rdchk(`SDDC_ADDR_MASK, 8'h01, "mask");
        wr(2'h3, 8'hFF);
        rdchk(2'h3, 8'h00, "unmapped");
        for (int c = 1; c < 16; c++) begin
            wr(`SDDC_ADDR_CTRL, 8'h10 | 8'(c));
            chk("trip", 8'(trip_level_select_o), 8'(c));
            chk("ext_sel", 8'(ext_input_select_o), 8'(c == 15));
        end
        wr(`SDDC_ADDR_CTRL, 8'h05);
        chk("power_off", 8'(detect_power_enable_o), 8'h00);
        chk("stable_off", 8'(ref_stable_flag_o), 8'h00);
        @(posedge clk_i);
        ref_ready_i <= 1'b0;
        bor_ref_running_i <= 1'b1;
        comparator_below_i <= 1'b0;
        wr(`SDDC_ADDR_STAT, 8'h03);
        idle(4);
        wr(`SDDC_ADDR_CTRL, 8'h15);
        wait_stable();
        chk("no_settle", 8'(ref_settle_o), 8'h00);
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        rdchk(`SDDC_ADDR_CTRL, 8'h05, "ctrl_rereset");
        chk("power_rst", 8'(detect_power_enable_o), 8'h00);
        rdchk(`SDDC_ADDR_MASK, 8'h00, "mask_reset");
        finish_test();
    end
endmodule
